// ==== rtl/lcd_pkg.sv ====
// Shared constants, types and helpers for the LCD mux controller
package lcd_pkg;
  localparam int MCLK_MHZ      = 250;
  localparam int REF_LOSS_US   = 100;
  localparam int MAX_COMS      = 4;
  localparam int BYTES_PER_COM = 6;
  localparam int RAM_BYTES     = MAX_COMS * BYTES_PER_COM;
  localparam int RAM_AW        = 5;
  localparam int SEG_BITS      = 48;
  localparam int SLOT_W        = 2;
  localparam int PRE_W         = 9;
  localparam int BASE_W        = 10;

  localparam logic [7:0]          MODE_ADDR       = 8'hdc;
  localparam logic [7:0]          RAM_FIRST       = 8'he0;
  localparam logic [7:0]          RAM_LAST        = 8'hf7;
  localparam logic [7:0]          MODE_RESET      = 8'h00;
  localparam logic [7:0]          RDATA_IDLE      = 8'h00;
  localparam logic [SEG_BITS-1:0] UNUSED_SEG_MASK = 48'h0000_0000_0007;
  localparam logic [MAX_COMS-1:0] COM_FIRST       = 4'h1;

  localparam logic [1:0] MUX_1_4 = 2'h0;
  localparam logic [1:0] MUX_1_1 = 2'h1;
  localparam logic [1:0] MUX_1_2 = 2'h2;
  localparam logic [1:0] MUX_1_3 = 2'h3;
  localparam logic [2:0] COMS_1  = 3'h1;
  localparam logic [2:0] COMS_2  = 3'h2;
  localparam logic [2:0] COMS_3  = 3'h3;
  localparam logic [2:0] COMS_4  = 3'h4;

  localparam logic [2:0] SRC_OFF    = 3'h0;
  localparam logic [2:0] SRC_AUX    = 3'h1;
  localparam logic [2:0] SRC_RSV_A  = 3'h2;
  localparam logic [2:0] SRC_DIV32  = 3'h3;
  localparam logic [2:0] SRC_DIV64  = 3'h4;
  localparam logic [2:0] SRC_DIV128 = 3'h5;
  localparam logic [2:0] SRC_DIV256 = 3'h6;
  localparam logic [2:0] SRC_RSV_B  = 3'h7;

  localparam logic [PRE_W-1:0] PRE_DIV32  = 9'h020;
  localparam logic [PRE_W-1:0] PRE_DIV64  = 9'h040;
  localparam logic [PRE_W-1:0] PRE_DIV128 = 9'h080;
  localparam logic [PRE_W-1:0] PRE_DIV256 = 9'h100;

  localparam logic [2:0]        BASE_RSV     = 3'h7;
  localparam logic [BASE_W-1:0] BASE_DIV_512 = 10'h200;
  localparam logic [BASE_W-1:0] BASE_DIV_386 = 10'h182;
  localparam logic [BASE_W-1:0] BASE_DIV_256 = 10'h100;
  localparam logic [BASE_W-1:0] BASE_DIV_192 = 10'h0c0;
  localparam logic [BASE_W-1:0] BASE_DIV_128 = 10'h080;
  localparam logic [BASE_W-1:0] BASE_DIV_96  = 10'h060;
  localparam logic [BASE_W-1:0] BASE_DIV_64  = 10'h040;

  typedef struct packed {
    logic [1:0] mux;
    logic [2:0] src;
    logic [2:0] base;
  } mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef enum logic {DISP_OFF, DISP_RUN} disp_state_t;
  typedef enum logic [1:0] {RSEL_NONE, RSEL_MODE, RSEL_RAM} rd_sel_t;

  function automatic logic [PRE_W-1:0] pre_factor(input logic [2:0] src);
    case (src)
      SRC_DIV64:  return PRE_DIV64;
      SRC_DIV128: return PRE_DIV128;
      SRC_DIV256: return PRE_DIV256;
      default:    return PRE_DIV32;
    endcase
  endfunction

  function automatic logic [BASE_W-1:0] base_factor(input logic [2:0] base);
    case (base)
      3'h0:    return BASE_DIV_512;
      3'h1:    return BASE_DIV_386;
      3'h2:    return BASE_DIV_256;
      3'h3:    return BASE_DIV_192;
      3'h4:    return BASE_DIV_128;
      3'h5:    return BASE_DIV_96;
      default: return BASE_DIV_64;
    endcase
  endfunction

  function automatic logic [2:0] com_count(input logic [1:0] mux);
    case (mux)
      MUX_1_1: return COMS_1;
      MUX_1_2: return COMS_2;
      MUX_1_3: return COMS_3;
      default: return COMS_4;
    endcase
  endfunction

  function automatic logic src_is_main(input logic [2:0] src);
    return (src == SRC_DIV32) || (src == SRC_DIV64) || (src == SRC_DIV128) ||
           (src == SRC_DIV256);
  endfunction

  function automatic logic src_is_ok(input logic [2:0] src);
    return (src == SRC_AUX) || src_is_main(src);
  endfunction
endpackage

// ==== rtl/lcd_ram.sv ====
// Display pattern memory with registered bus read and row read
module lcd_ram
#(
  parameter int DEPTH     = lcd_pkg::RAM_BYTES,
  parameter int ROW_BYTES = lcd_pkg::BYTES_PER_COM,
  parameter int AW        = lcd_pkg::RAM_AW,
  parameter int SEL_W     = lcd_pkg::SLOT_W
)
(
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  input  wire logic [AW-1:0]          addr_in,
  input  wire logic [7:0]             wdata_in,
  output logic      [7:0]             rdata_out,
  input  wire logic [SEL_W-1:0]       row_sel_in,
  output logic      [ROW_BYTES*8-1:0] row_out
);
  if ((DEPTH % ROW_BYTES != 0) || (DEPTH > 2 ** AW) || (DEPTH / ROW_BYTES > 2 ** SEL_W))
  begin : g_check
    $error("lcd_ram geometry not supported");
  end

  logic [7:0]             mem [DEPTH];
  logic [AW-1:0]          row_base;
  logic [ROW_BYTES*8-1:0] row_w;

  assign row_base = AW'(int'(row_sel_in) * ROW_BYTES);

  // Row gather, one byte per lane
  for (genvar j = 0; j < ROW_BYTES; j++)
  begin : g_row
    assign row_w[j*8 +: 8] = mem[row_base + AW'(j)];
  end

  // Contents keep no reset value [R10]
  always_ff @(posedge mclk_in)
  begin
    if (wr_in)
      mem[addr_in] <= wdata_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      rdata_out <= '0;
    else if (rd_in)
      rdata_out <= mem[addr_in];
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      row_out <= '0;
    else
      row_out <= row_w;
  end
endmodule

// ==== rtl/lcd_timebase.sv ====
// Reference prescaler and base rate divider for the LCD controller
module lcd_timebase
#(
  parameter int PRE_W  = lcd_pkg::PRE_W,
  parameter int BASE_W = lcd_pkg::BASE_W
)
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] src_in,
  input  wire logic [2:0] base_in,
  input  wire logic       aux_tick_in,
  input  wire logic       ref_en_in,
  input  wire logic       base_en_in,
  output logic            ref_tick_out,
  output logic            slot_tick_out
);
  import lcd_pkg::*;

  if ((PRE_W < lcd_pkg::PRE_W) || (BASE_W < lcd_pkg::BASE_W))
  begin : g_check
    $error("lcd_timebase counters too narrow");
  end

  logic [PRE_W-1:0]  pre_cnt;
  logic [PRE_W-1:0]  pre_last;
  logic [BASE_W-1:0] base_cnt;
  logic [BASE_W-1:0] base_last;
  logic              pre_wrap;

  assign pre_last      = PRE_W'(pre_factor(src_in) - 1'b1);
  assign base_last     = BASE_W'(base_factor(base_in) - 1'b1);
  assign pre_wrap      = (pre_cnt == pre_last);
  assign ref_tick_out  = ref_en_in && ((src_in == SRC_AUX) ? aux_tick_in : pre_wrap); // [R4]
  assign slot_tick_out = base_en_in && ref_tick_out && (base_cnt == base_last);

  // Internal clock prescaler [R14]
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !ref_en_in || (src_in == SRC_AUX))
      pre_cnt <= '0;
    else if (pre_wrap)
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + 1'b1;
  end

  // Base rate divider, one slot per wrap [R2]
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !base_en_in)
      base_cnt <= '0;
    else if (ref_tick_out)
      base_cnt <= (base_cnt == base_last) ? '0 : base_cnt + 1'b1;
  end

  // Checker helpers
  logic [2:0]      src_q;
  logic [2:0]      base_q;
  logic [PRE_W:0]  gap;
  logic            gap_ok;
  logic [BASE_W:0] refs;
  logic            refs_ok;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      src_q   <= SRC_OFF;
      base_q  <= '0;
      gap     <= '0;
      gap_ok  <= 1'b0;
      refs    <= '0;
      refs_ok <= 1'b0;
    end
    else
    begin
      src_q  <= src_in;
      base_q <= base_in;
      gap    <= ref_tick_out ? '0 : gap + 1'b1;
      if (!ref_en_in || (src_in != src_q) || (src_in == SRC_AUX))
        gap_ok <= 1'b0;
      else if (ref_tick_out)
        gap_ok <= 1'b1;
      if (slot_tick_out)
        refs <= '0;
      else if (ref_tick_out)
        refs <= refs + 1'b1;
      if (!base_en_in || (base_in != base_q))
        refs_ok <= 1'b0;
      else if (slot_tick_out)
        refs_ok <= 1'b1;
    end
  end

  a_prescale_gap: assert property ( // [R14]
    @(posedge mclk_in) disable iff (rst_in)
    ref_tick_out && gap_ok && (src_in == src_q) && src_is_main(src_in)
    |-> gap == (PRE_W + 1)'(pre_factor(src_in) - 1'b1))
  else $error("Reference tick spacing wrong");

  a_base_divide: assert property ( // [R2]
    @(posedge mclk_in) disable iff (rst_in)
    slot_tick_out && refs_ok && (base_in == base_q)
    |-> refs == (BASE_W + 1)'(base_factor(base_in) - 1'b1))
  else $error("Base divider factor wrong");
endmodule

// ==== rtl/lcd_mux_controller.sv ====
// Multiplexed segment LCD controller top level
// Functional notes
// R1: Mux selector 00=1/4, 01=1/1, 10=1/2, 11=1/3 picks active backplanes.
// R2: Base selector divides reference by 512,386,256,192,128,96,64; code 111 reserved.
// R3: Frame rate is base rate divided by number of active backplanes.
// R4: Source 000 off, 001 auxiliary oscillator, 010/111 reserved, others divide clock.
// R5: STOP with main clock source turns display off, all outputs grounded.
// R6: Source change applies at frame end; earlier STOP acts as main source.
// R7: Software selects auxiliary source and waits a frame before STOP.
// R8: Bias divider disabled whenever the display driver is off.
// R9: Element is on while its RAM bit is set, off while cleared.
// R10: Display RAM is not initialised by reset.
// R11: RAM of unused backplanes stays read/write storage and is not shown.
// R12: Six bytes per backplane E0..F7, commons in order, MSB highest segment.
// R13: Mode register bits 7-6 mux, 5-3 source, 2-0 base rate.
// R14: Clock division 32, 64, 128, 256 for source codes 011 to 110.
// R15: Loss of reference clock grounds all segment and common outputs.
// R16: Backplanes activated in turn in equal slots; segments follow RAM.
//
// Decided for this implementation: the strobed register port.
module lcd_mux_controller
#(
  parameter int REF_LOSS_CYCLES = lcd_pkg::REF_LOSS_US * lcd_pkg::MCLK_MHZ
)
(
  input  wire logic                             mclk_in,
  input  wire logic                             rst_in,
  input  wire lcd_pkg::bus_req_t                bus_in,
  output logic      [7:0]                       rdata_out,
  input  wire logic                             aux_osc_tick_in,
  input  wire logic                             stop_in,
  output logic      [lcd_pkg::SEG_BITS-1:0]     seg_out,
  output logic      [lcd_pkg::MAX_COMS-1:0]     backplane_out,
  output logic                                  display_on_out,
  output logic                                  bias_enable_out
);
  import lcd_pkg::*;

  localparam int LOSS_W = $clog2(REF_LOSS_CYCLES + 1);

  if (REF_LOSS_CYCLES < 2)
  begin : g_check
    $error("REF_LOSS_CYCLES too small");
  end

  mode_t                mode_q;
  logic [2:0]           eff_src;
  logic [1:0]           eff_mux;
  logic                 stopped;
  logic                 ref_lost;
  logic [LOSS_W-1:0]    loss_cnt;
  logic [SLOT_W-1:0]    slot;
  logic [SLOT_W-1:0]    last_slot;
  logic [SLOT_W-1:0]    next_slot;
  disp_state_t          state;
  disp_state_t          next_state;
  logic                 running;
  logic                 run_ok;
  logic                 frame_end;
  logic                 ref_tick;
  logic                 slot_tick;
  logic                 ram_hit;
  logic [RAM_AW-1:0]    ram_addr;
  logic [7:0]           ram_rdata;
  logic [SEG_BITS-1:0]  ram_row;
  rd_sel_t              rd_sel;
  logic [7:0]           rd_mode;

  // Register decode
  assign ram_hit  = (bus_in.addr >= RAM_FIRST) && (bus_in.addr <= RAM_LAST); // [R12]
  assign ram_addr = RAM_AW'(bus_in.addr - RAM_FIRST); // [R12]

  // Mode register, fields by struct layout [R13]
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      mode_q <= mode_t'(MODE_RESET);
    else if (bus_in.wr && (bus_in.addr == MODE_ADDR))
      mode_q <= mode_t'(bus_in.wdata);
  end

  // Read path, data one cycle after strobe
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rd_sel  <= RSEL_NONE;
      rd_mode <= RDATA_IDLE;
    end
    else if (bus_in.rd)
    begin
      rd_mode <= mode_q;
      if (bus_in.addr == MODE_ADDR)
        rd_sel <= RSEL_MODE;
      else if (ram_hit)
        rd_sel <= RSEL_RAM;
      else
        rd_sel <= RSEL_NONE;
    end
    else
      rd_sel <= RSEL_NONE;
  end

  always_comb
  begin
    case (rd_sel)
      RSEL_MODE: rdata_out = rd_mode;
      RSEL_RAM:  rdata_out = ram_rdata;
      default:   rdata_out = RDATA_IDLE;
    endcase
  end

  // All rows are storage regardless of mux ratio [R11]
  lcd_ram u_ram (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .wr_in      (bus_in.wr && ram_hit),
    .rd_in      (bus_in.rd && ram_hit),
    .addr_in    (ram_addr),
    .wdata_in   (bus_in.wdata),
    .rdata_out  (ram_rdata),
    .row_sel_in (next_slot),
    .row_out    (ram_row)
  );

  lcd_timebase u_timebase (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .src_in        (eff_src),
    .base_in       (mode_q.base),
    .aux_tick_in   (aux_osc_tick_in),
    .ref_en_in     (src_is_ok(eff_src)),
    .base_en_in    (running),
    .ref_tick_out  (ref_tick),
    .slot_tick_out (slot_tick)
  );

  // Source and ratio latched only at frame end while running [R6] [R7]
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      eff_src <= SRC_OFF;
      eff_mux <= MUX_1_4;
    end
    else if (!running || frame_end)
    begin
      eff_src <= mode_q.src;
      eff_mux <= mode_q.mux;
    end
  end

  // STOP on main source holds off until STOP ends [R5] [R6]
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !stop_in)
      stopped <= 1'b0;
    else if (src_is_main(eff_src))
      stopped <= 1'b1;
  end

  // Reference supervisor [R15]
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !src_is_ok(eff_src) || ref_tick)
    begin
      loss_cnt <= '0;
      ref_lost <= 1'b0;
    end
    else if (loss_cnt == LOSS_W'(REF_LOSS_CYCLES - 1))
      ref_lost <= 1'b1;
    else
      loss_cnt <= loss_cnt + 1'b1;
  end

  assign run_ok = src_is_ok(eff_src) && (mode_q.base != BASE_RSV) && !stopped && // [R2] [R4]
                  !(stop_in && src_is_main(eff_src)) && !ref_lost; // [R5] [R15]

  always_comb
  begin
    next_state = state;
    case (state)
      DISP_OFF:
        if (run_ok)
          next_state = DISP_RUN;
      DISP_RUN:
        if (!run_ok)
          next_state = DISP_OFF;
      default:
        next_state = DISP_OFF;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      state <= DISP_OFF;
    else
      state <= next_state;
  end

  assign running = (state == DISP_RUN);

  // Slot sequencing, frame of N base periods [R1] [R3] [R16]
  assign last_slot = SLOT_W'(com_count(eff_mux) - 1'b1);
  assign frame_end = running && slot_tick && (slot == last_slot);

  always_comb
  begin
    if (!running || frame_end)
      next_slot = '0;
    else if (slot_tick)
      next_slot = slot + 1'b1;
    else
      next_slot = slot;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      slot <= '0;
    else
      slot <= next_slot;
  end

  // Panel outputs grounded whenever off [R5] [R9] [R15] [R16]
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !running)
    begin
      seg_out        <= '0;
      backplane_out  <= '0;
      display_on_out <= 1'b0;
    end
    else
    begin
      seg_out        <= ram_row & ~UNUSED_SEG_MASK;
      backplane_out  <= COM_FIRST << slot;
      display_on_out <= 1'b1;
    end
  end

  assign bias_enable_out = display_on_out; // [R8]

  // Checker helpers
  logic [2:0] slots_seen;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !running || frame_end)
      slots_seen <= '0;
    else if (slot_tick)
      slots_seen <= slots_seen + 1'b1;
  end

  a_off_dark: assert property ( // [R5] [R15]
    @(posedge mclk_in) disable iff (rst_in)
    !display_on_out |-> (seg_out == '0) && (backplane_out == '0))
  else $error("Outputs driven while display off");

  a_bias_tracks: assert property ( // [R8]
    @(posedge mclk_in) disable iff (rst_in)
    bias_enable_out == (backplane_out != '0))
  else $error("Bias enable disagrees with backplane drive");

  a_stop_main_off: assert property ( // [R5]
    @(posedge mclk_in) disable iff (rst_in)
    stop_in && src_is_main(eff_src) |-> ##2 !display_on_out)
  else $error("Display still on in STOP with main source");

  a_src_frame_end: assert property ( // [R6]
    @(posedge mclk_in) disable iff (rst_in)
    $past(running) && (eff_src != $past(eff_src)) |-> $past(frame_end))
  else $error("Source changed inside a frame");

  a_reserved_off: assert property ( // [R2] [R4]
    @(posedge mclk_in) disable iff (rst_in)
    (mode_q.base == BASE_RSV) || !src_is_ok(eff_src) |-> ##2 !display_on_out)
  else $error("Display on with reserved or disabled setting");

  a_loss_off: assert property ( // [R15]
    @(posedge mclk_in) disable iff (rst_in)
    ref_lost |-> ##2 !display_on_out)
  else $error("Display on after reference loss");

  a_com_onehot: assert property ( // [R16]
    @(posedge mclk_in) disable iff (rst_in)
    display_on_out |-> $onehot(backplane_out))
  else $error("Backplanes not one at a time");

  a_com_in_ratio: assert property ( // [R1]
    @(posedge mclk_in) disable iff (rst_in)
    display_on_out |-> (backplane_out >> $past(com_count(eff_mux))) == '0)
  else $error("Inactive backplane driven");

  a_frame_length: assert property ( // [R3]
    @(posedge mclk_in) disable iff (rst_in)
    frame_end |-> slots_seen == (com_count(eff_mux) - 1'b1))
  else $error("Frame length not equal to backplane count");

  a_seg_from_ram: assert property ( // [R9] [R12]
    @(posedge mclk_in) disable iff (rst_in)
    display_on_out |-> seg_out == ($past(ram_row) & ~UNUSED_SEG_MASK))
  else $error("Segment pattern differs from display RAM");

  a_mode_readback: assert property ( // [R13]
    @(posedge mclk_in) disable iff (rst_in)
    bus_in.rd && (bus_in.addr == MODE_ADDR) |=> rdata_out == $past(mode_q))
  else $error("Mode register readback wrong");

  a_ram_readback: assert property ( // [R11]
    @(posedge mclk_in) disable iff (rst_in)
    $past(bus_in.wr && ram_hit) && bus_in.rd && (bus_in.addr == $past(bus_in.addr))
    |=> rdata_out == $past(bus_in.wdata, 2))
  else $error("Display RAM readback wrong");

  c_full_frame: cover property (
    @(posedge mclk_in) disable iff (rst_in)
    frame_end && (eff_mux == MUX_1_4));

  c_stop_on_aux: cover property (
    @(posedge mclk_in) disable iff (rst_in)
    stop_in && display_on_out && (eff_src == SRC_AUX));

  c_ref_loss: cover property (
    @(posedge mclk_in) disable iff (rst_in)
    $rose(ref_lost));
endmodule

// ==== tb/lcd_panel_model.sv ====
// Behavioural LCD glass: latches lit elements and counts bias faults
module lcd_panel_model
(
  input  wire logic                         mclk_in,
  input  wire logic [lcd_pkg::SEG_BITS-1:0] seg_in,
  input  wire logic [lcd_pkg::MAX_COMS-1:0] plane_in,
  input  wire logic                         on_in,
  input  wire logic                         bias_in,
  output int                                faults_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_pkg::*;
  logic [SEG_BITS-1:0] lit [MAX_COMS];
  logic                on_q = 1'b0;
  initial faults_out = 0;
  // One cycle of slack while the driver turns off
  always @(posedge mclk_in)
  begin
    on_q <= on_in;
    for (int c = 0; c < MAX_COMS; c++)
      if (plane_in[c] === 1'b1)
        lit[c] <= seg_in;
    faults_out <= faults_out
      + int'(!on_in && !on_q && (seg_in !== '0 || plane_in !== '0))
      + int'(bias_in !== on_in);
  end
endmodule

// ==== tb/test_lcd_mux_controller.sv ====
// Self-checking bench for the LCD mux controller
module test_lcd_mux_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_pkg::*;
  localparam int LOSS = 300;
  localparam int AUXP = 4;
  logic                mclk_in         = 1'b0;
  logic                rst_in          = 1'b1;
  bus_req_t            bus_in          = '0;
  logic                aux_osc_tick_in = 1'b0;
  logic                stop_in         = 1'b0;
  logic                aux_run         = 1'b1;
  logic [7:0]          rdata_out;
  logic [SEG_BITS-1:0] seg_out;
  logic [MAX_COMS-1:0] backplane_out;
  logic                display_on_out;
  logic                bias_enable_out;
  logic [7:0]          shadow [RAM_BYTES];
  logic [7:0]          rd_v;
  int                  n_mismatch = 0;
  int                  tests_run  = 0;
  int                  faults;
  int                  cyc        = 0;
  int                  bad;
  int                  bf [7]     = '{512, 386, 256, 192, 128, 96, 64};
  int                  pf [4]     = '{32, 64, 128, 256};
  logic [7:0]          rsv [4];

  lcd_mux_controller #(.REF_LOSS_CYCLES(LOSS)) u_dut
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .aux_osc_tick_in(aux_osc_tick_in), .stop_in(stop_in), .seg_out(seg_out),
    .backplane_out(backplane_out), .display_on_out(display_on_out),
    .bias_enable_out(bias_enable_out)
  );
  lcd_panel_model u_panel
  (
    .mclk_in(mclk_in), .seg_in(seg_out), .plane_in(backplane_out),
    .on_in(display_on_out), .bias_in(bias_enable_out), .faults_out(faults)
  );

  initial
    forever #2 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    aux_osc_tick_in <= aux_run && (cyc % AUXP == 0);
  end

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in) bus_in <= {a, d, 1'b1, 1'b0};
    @(posedge mclk_in) bus_in <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in) bus_in <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk_in) bus_in <= '0;
    #1 d = rdata_out;
  endtask
  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk_in) bus_in <= {a, d, 1'b1, 1'b0};
    @(posedge mclk_in) bus_in <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk_in) bus_in <= '0;
    #1 q = rdata_out;
  endtask
  task automatic do_reset();
    @(posedge mclk_in) rst_in <= 1'b1;
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
  endtask
  task automatic wait_on(input logic exp);
    for (int i = 0; i < 8 && display_on_out !== exp; i++)
    begin
      @(posedge mclk_in);
      #1;
    end
    check(display_on_out, exp, "display state");
  endtask
  task automatic slot(input int start, output int len);
    logic [MAX_COMS-1:0] p;
    p = backplane_out;
    len = start;
    while (backplane_out === p && len < 40000)
    begin
      @(posedge mclk_in);
      #1 len++;
    end
  endtask
  function automatic logic [47:0] row(input int c);
    return {shadow[6*c+5], shadow[6*c+4], shadow[6*c+3], shadow[6*c+2],
            shadow[6*c+1], shadow[6*c]} & ~UNUSED_SEG_MASK;
  endfunction
  // Starts from reset, measures nm slots after the first change
  task automatic run_mode(input logic [7:0] m, input int n, input int nm, input int len);
    int l;
    do_reset();
    wr(MODE_ADDR, m);
    wait_on(1'b1);
    check(backplane_out, COM_FIRST, "first backplane");
    slot(0, l);
    for (int k = 0; k < nm; k++)
    begin
      check(backplane_out, COM_FIRST << ((k + 1) % n), "backplane");
      repeat (2) @(posedge mclk_in);
      #1 check(seg_out, row((k + 1) % n), "segments");
      slot(2, l);
      check(l, len, "slot length");
    end
  endtask

  initial
  begin
    do_reset();
    #1 check(display_on_out, 1'b0, "reset on");
    check({bias_enable_out, backplane_out, seg_out}, '0, "reset outputs");
    rd(MODE_ADDR, rd_v);
    check(rd_v, MODE_RESET, "mode reset");
    for (int i = 0; i < RAM_BYTES; i++)
    begin
      shadow[i] = 8'h5a ^ 8'(i * 37);
      wr(RAM_FIRST + 8'(i), shadow[i]);
    end
    do_reset();
    for (int i = 0; i < RAM_BYTES; i++)
    begin
      rd(RAM_FIRST + 8'(i), rd_v);
      check(rd_v, shadow[i], "ram readback");
    end
    shadow[5] = 8'ha5;
    wr_rd(RAM_FIRST + 8'h05, shadow[5], rd_v);
    check(rd_v, shadow[5], "write then read");
    wr(8'hf8, 8'hff);
    rd(8'hf8, rd_v);
    check(rd_v, RDATA_IDLE, "unmapped");
    wr(MODE_ADDR, 8'h4c);
    rd(MODE_ADDR, rd_v);
    check(rd_v, 8'h4c, "mode readback");
    run_mode({MUX_1_3, SRC_AUX, 3'h6}, 3, 3, AUXP * bf[6]);
    run_mode({MUX_1_4, SRC_AUX, 3'h6}, 4, 4, AUXP * bf[6]);
    for (int c = 0; c < MAX_COMS; c++)
      check(u_panel.lit[c], row(c), "panel pattern");
    for (int p = 0; p < 4; p++)
      run_mode({MUX_1_2, SRC_DIV32 + 3'(p), 3'h6}, 2, 1, 64 * pf[p]);
    for (int b = 0; b < 7; b++)
      run_mode({MUX_1_2, SRC_AUX, 3'(b)}, 2, 1, AUXP * bf[b]);
    do_reset();
    wr(MODE_ADDR, {MUX_1_1, SRC_AUX, 3'h6});
    wait_on(1'b1);
    bad = 0;
    repeat (600)
    begin
      @(posedge mclk_in);
      #1 bad += int'(backplane_out !== COM_FIRST || seg_out !== row(0));
    end
    check(bad, 0, "single backplane");
    aux_run = 1'b0;
    repeat (LOSS + 8) @(posedge mclk_in);
    #1 check({display_on_out, backplane_out, seg_out}, '0, "reference loss");
    aux_run = 1'b1;
    do_reset();
    wr(MODE_ADDR, {MUX_1_1, SRC_DIV32, 3'h6});
    wait_on(1'b1);
    wr(MODE_ADDR, {MUX_1_1, SRC_AUX, 3'h6});
    @(posedge mclk_in) stop_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    #1 check(display_on_out, 1'b0, "stop before frame end");
    @(posedge mclk_in) stop_in <= 1'b0;
    repeat (4200) @(posedge mclk_in);
    stop_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    #1 check(display_on_out, 1'b1, "stop on auxiliary");
    @(posedge mclk_in) stop_in <= 1'b0;
    rsv = '{{MUX_1_4, SRC_DIV32, BASE_RSV}, {MUX_1_4, SRC_OFF, 3'h6},
            {MUX_1_4, SRC_RSV_A, 3'h6}, {MUX_1_4, SRC_RSV_B, 3'h6}};
    for (int r = 0; r < 4; r++)
    begin
      do_reset();
      wr(MODE_ADDR, rsv[r]);
      repeat (8) @(posedge mclk_in);
      #1 check(display_on_out, 1'b0, "reserved code");
    end
    check(faults, 0, "panel bias faults");
    close_out();
  end
  initial
  begin
    repeat (95000) @(posedge mclk_in);
    n_mismatch++;
    close_out();
  end
endmodule
